// *** verilog/tcirq_pkg.sv ***
package tcirq_pkg;

  // Register port widths
  localparam int unsigned TCIRQ_ADDR_W = 8;
  localparam int unsigned TCIRQ_DATA_W = 8;

  // Register offsets on the two-wire register port
  localparam logic [7:0] TCIRQ_OFS_CONN = 8'h02;
  localparam logic [7:0] TCIRQ_OFS_CHG = 8'h03;
  localparam logic [7:0] TCIRQ_OFS_SUP = 8'h04;
  localparam logic [7:0] TCIRQ_OFS_ACC = 8'h05;
  localparam logic [7:0] TCIRQ_OFS_RES = 8'h06;

  // Common reset value of every flag register
  localparam logic [7:0] TCIRQ_FLAGS_RST = 8'h00;

  // Connector event flag positions
  localparam int unsigned TCIRQ_CONN_STATE_BIT = 5;
  localparam int unsigned TCIRQ_PIN_ORIENT_BIT = 4;
  localparam int unsigned TCIRQ_ADV_CURRENT_BIT = 3;
  localparam int unsigned TCIRQ_CABLE_POWER_BIT = 2;
  localparam int unsigned TCIRQ_CABLE_OC_BIT = 1;
  localparam int unsigned TCIRQ_DETECT_ABORT_BIT = 0;

  // Charge detection event flag positions
  localparam int unsigned TCIRQ_CHARGER_KIND_BIT = 4;
  localparam int unsigned TCIRQ_VENDOR_KIND_BIT = 3;
  localparam int unsigned TCIRQ_RUN_RISE_BIT = 2;
  localparam int unsigned TCIRQ_RUN_FALL_BIT = 1;
  localparam int unsigned TCIRQ_CONTACT_TMO_BIT = 0;

  // Supply path event flag positions
  localparam int unsigned TCIRQ_SUPPLY_SWITCH_BIT = 1;
  localparam int unsigned TCIRQ_SUPPLY_OVERVOLT_BIT = 0;

  // Accessory resistor flags occupy bits 0 up to this count minus one
  localparam int unsigned TCIRQ_ACC_COUNT = 5;

  // Resistance result event flag positions
  localparam int unsigned TCIRQ_RES_GROUND_BIT = 5;
  localparam int unsigned TCIRQ_RES_DONE_BIT = 4;
  localparam int unsigned TCIRQ_RES_FINITE_BIT = 3;
  localparam int unsigned TCIRQ_RES_OPEN_BIT = 2;
  localparam int unsigned TCIRQ_RES_ABORT_BIT = 1;
  localparam int unsigned TCIRQ_RES_MOIST_BIT = 0;

  // Status field widths
  localparam int unsigned TCIRQ_CONN_STATE_W = 3;
  localparam int unsigned TCIRQ_PIN_ORIENT_W = 2;
  localparam int unsigned TCIRQ_ADV_CURRENT_W = 2;
  localparam int unsigned TCIRQ_CHARGER_KIND_W = 2;
  localparam int unsigned TCIRQ_VENDOR_KIND_W = 4;

  // How a flag cell recognises its event
  typedef enum logic [1:0] {
    TCIRQ_ON_CHANGE,
    TCIRQ_ON_RISE,
    TCIRQ_ON_FALL,
    TCIRQ_ON_PULSE
  } tcirq_kind_t;

  // Connector state machine status
  typedef struct packed {
    logic [TCIRQ_CONN_STATE_W-1:0] conn_state;
    logic [TCIRQ_PIN_ORIENT_W-1:0] pin_orient;
    logic [TCIRQ_ADV_CURRENT_W-1:0] adv_current;
    logic cable_power_state;
    logic cable_power_overcurrent;
    logic detect_abort;
  } tcirq_conn_stat_t;

  // Charging detection machine status
  typedef struct packed {
    logic [TCIRQ_CHARGER_KIND_W-1:0] charger_kind;
    logic [TCIRQ_VENDOR_KIND_W-1:0] vendor_charger_kind;
    logic detect_running;
    logic contact_timeout;
  } tcirq_chg_stat_t;

  // Supply switch supervisor status
  typedef struct packed {
    logic switch_closed;
    logic overvolt;
  } tcirq_sup_stat_t;

  // Resistance and moisture measurement result strobes
  typedef struct packed {
    logic [TCIRQ_ACC_COUNT-1:0] accessory;
    logic grounded;
    logic meas_done;
    logic invalid_finite;
    logic open;
    logic aborted;
    logic moisture_valid;
  } tcirq_res_evt_t;

  // One register access from the two-wire register engine
  typedef struct packed {
    logic wr;
    logic rd;
    logic [TCIRQ_ADDR_W-1:0] addr;
    logic [TCIRQ_DATA_W-1:0] wdata;
  } tcirq_reg_req_t;

endpackage

// *** verilog/tcirq_evt_flag.sv ***
`timescale 1ns/1ns
module tcirq_evt_flag
  import tcirq_pkg::*;
#(
  parameter int unsigned W = 1,
  parameter tcirq_kind_t KIND = TCIRQ_ON_CHANGE
) (
  input wire logic core_clk, // System clock
  input wire logic rst_b, // Asynchronous reset, active low
  input wire logic [W-1:0] src, // Watched status or strobe
  input wire logic clr, // Write-one clear of this flag
  output logic flag // Sticky event flag
);

  import tcirq_pkg::*;

  // Elaboration check: a zero-width watched field cannot be served
  if (W < 1) begin : g_bad_w
    $error("tcirq_evt_flag needs W of at least one");
  end

  logic [W-1:0] prev_r; // Status seen last cycle
  logic primed_r; // Baseline captured after reset
  logic hit; // Event seen this cycle
  logic flag_r; // Flag state

  // Track previous status; for change and edge kinds the first cycle only takes a baseline
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_r <= '0;
      primed_r <= 1'b0;
    end else begin
      prev_r <= src;
      primed_r <= 1'b1;
    end
  end

  // Recognise the event in the chosen manner
  always_comb begin
    unique case (KIND)
      TCIRQ_ON_CHANGE: hit = primed_r && (src != prev_r);
      TCIRQ_ON_RISE: hit = primed_r && src[0] && !prev_r[0];
      TCIRQ_ON_FALL: hit = primed_r && !src[0] && prev_r[0];
      TCIRQ_ON_PULSE: hit = |src; // Strobes count in any cycle they are high
    endcase
  end

  // Sticky flag; a new event wins over a clear in the same cycle
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= hit | (flag_r & ~clr);
    end
  end

  assign flag = flag_r;

endmodule

// *** verilog/tcirq_flags.sv ***
`timescale 1ns/1ns
// What this block does
// - Connector state change sets connector bit five
// - Pin orientation change sets connector bit four
// - Advertised current change sets connector bit three
// - Cable power on/off change sets bit two
// - Cable power overcurrent change sets bit one
// - Detection abort event sets connector bit zero
// - Charger type change sets charge bit four
// - Detection run start sets charge bit two
// - Detection run end sets charge bit one
// - Contact timeout change sets charge bit zero
// - Supply switch change sets supply bit one
// - Supply overvoltage change sets supply bit zero
// - Valid accessory one to five sets bits
// - Measurement done bit four, moisture bit zero
// - Ground, finite, open, abort set result bits
module tcirq_flags
  import tcirq_pkg::*;
(
  input wire logic core_clk, // System clock, 50 MHz
  input wire logic rst_b, // Asynchronous reset, active low
  input tcirq_pkg::tcirq_conn_stat_t conn_stat, // Connector machine status
  input tcirq_pkg::tcirq_chg_stat_t chg_stat, // Charging detection status
  input tcirq_pkg::tcirq_sup_stat_t sup_stat, // Supply switch status
  input tcirq_pkg::tcirq_res_evt_t res_evt, // Measurement result strobes
  input tcirq_pkg::tcirq_reg_req_t reg_req, // Register access request
  output logic [tcirq_pkg::TCIRQ_DATA_W-1:0] reg_rdata, // Read data, registered
  output logic reg_rvalid, // Read data valid pulse
  output logic flag_pending // Any flag set, registered
);

  import tcirq_pkg::*;

  // Elaboration checks: the register images below are built for byte-wide registers
  if (TCIRQ_DATA_W != 8) begin : g_bad_data_w
    $error("tcirq_flags needs byte-wide registers");
  end
  // Every accessory flag must fit into its register
  if (TCIRQ_ACC_COUNT > TCIRQ_DATA_W) begin : g_bad_acc_count
    $error("tcirq_flags has more accessory flags than register bits");
  end
  // The highest named flag positions must land inside their registers
  if ((TCIRQ_CONN_STATE_BIT >= TCIRQ_DATA_W) ||
      (TCIRQ_RES_GROUND_BIT >= TCIRQ_DATA_W)) begin : g_bad_pos
    $error("tcirq_flags places a flag outside its register");
  end

  logic [TCIRQ_DATA_W-1:0] conn_flags; // Connector event flags
  logic [TCIRQ_DATA_W-1:0] chg_flags; // Charge detection event flags
  logic [TCIRQ_DATA_W-1:0] sup_flags; // Supply path event flags
  logic [TCIRQ_DATA_W-1:0] acc_flags; // Accessory resistor event flags
  logic [TCIRQ_DATA_W-1:0] res_flags; // Resistance result event flags

  logic [TCIRQ_DATA_W-1:0] conn_clr; // Write-one clear masks
  logic [TCIRQ_DATA_W-1:0] chg_clr;
  logic [TCIRQ_DATA_W-1:0] sup_clr;
  logic [TCIRQ_DATA_W-1:0] acc_clr;
  logic [TCIRQ_DATA_W-1:0] res_clr;

  logic [TCIRQ_DATA_W-1:0] rdata_nxt; // Read mux output
  logic [TCIRQ_DATA_W-1:0] rdata_r; // Read data holder
  logic rvalid_r; // Read answer strobe
  logic pending_r; // Any-flag summary

  // Write decode: each written one clears the matching flag
  always_comb begin
    conn_clr = '0;
    chg_clr = '0;
    sup_clr = '0;
    acc_clr = '0;
    res_clr = '0;
    if (reg_req.wr) begin
      unique case (reg_req.addr)
        TCIRQ_OFS_CONN: conn_clr = reg_req.wdata;
        TCIRQ_OFS_CHG: chg_clr = reg_req.wdata;
        TCIRQ_OFS_SUP: sup_clr = reg_req.wdata;
        TCIRQ_OFS_ACC: acc_clr = reg_req.wdata;
        TCIRQ_OFS_RES: res_clr = reg_req.wdata;
        default: conn_clr = '0; // Unmapped writes are ignored
      endcase
    end
  end

  // Connector event flags; unused upper bits read as zero
  assign conn_flags[7:6] = 2'h0;

  // Any change of the three-bit connector state
  tcirq_evt_flag #(.W(TCIRQ_CONN_STATE_W), .KIND(TCIRQ_ON_CHANGE)) u_conn_state (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .src(conn_stat.conn_state),
    .clr(conn_clr[TCIRQ_CONN_STATE_BIT]),
    .flag(conn_flags[TCIRQ_CONN_STATE_BIT])
  );

  // Any change of the active-pin orientation
  tcirq_evt_flag #(.W(TCIRQ_PIN_ORIENT_W), .KIND(TCIRQ_ON_CHANGE)) u_pin_orient (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .src(conn_stat.pin_orient),
    .clr(conn_clr[TCIRQ_PIN_ORIENT_BIT]),
    .flag(conn_flags[TCIRQ_PIN_ORIENT_BIT])
  );

  // Any change of the advertised source current
  tcirq_evt_flag #(.W(TCIRQ_ADV_CURRENT_W), .KIND(TCIRQ_ON_CHANGE)) u_adv_current (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .src(conn_stat.adv_current),
    .clr(conn_clr[TCIRQ_ADV_CURRENT_BIT]),
    .flag(conn_flags[TCIRQ_ADV_CURRENT_BIT])
  );

  // Cable power output switched on or off
  tcirq_evt_flag #(.W(1), .KIND(TCIRQ_ON_CHANGE)) u_cable_power (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .src(conn_stat.cable_power_state),
    .clr(conn_clr[TCIRQ_CABLE_POWER_BIT]),
    .flag(conn_flags[TCIRQ_CABLE_POWER_BIT])
  );

  // Overcurrent status entered or left on the cable power output
  tcirq_evt_flag #(.W(1), .KIND(TCIRQ_ON_CHANGE)) u_cable_oc (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .src(conn_stat.cable_power_overcurrent),
    .clr(conn_clr[TCIRQ_CABLE_OC_BIT]),
    .flag(conn_flags[TCIRQ_CABLE_OC_BIT])
  );

  // Abort arrives as a one-cycle strobe from the connector machine
  tcirq_evt_flag #(.W(1), .KIND(TCIRQ_ON_PULSE)) u_detect_abort (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .src(conn_stat.detect_abort),
    .clr(conn_clr[TCIRQ_DETECT_ABORT_BIT]),
    .flag(conn_flags[TCIRQ_DETECT_ABORT_BIT])
  );

  // Charge detection event flags
  assign chg_flags[7:5] = 3'h0;

  // Any change of the standard charger type
  tcirq_evt_flag #(.W(TCIRQ_CHARGER_KIND_W), .KIND(TCIRQ_ON_CHANGE)) u_charger_kind (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .src(chg_stat.charger_kind),
    .clr(chg_clr[TCIRQ_CHARGER_KIND_BIT]),
    .flag(chg_flags[TCIRQ_CHARGER_KIND_BIT])
  );

  // Any change of the vendor-specific charger type
  tcirq_evt_flag #(.W(TCIRQ_VENDOR_KIND_W), .KIND(TCIRQ_ON_CHANGE)) u_vendor_kind (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .src(chg_stat.vendor_charger_kind),
    .clr(chg_clr[TCIRQ_VENDOR_KIND_BIT]),
    .flag(chg_flags[TCIRQ_VENDOR_KIND_BIT])
  );

  // Both edges of the running indicator are caught separately
  tcirq_evt_flag #(.W(1), .KIND(TCIRQ_ON_RISE)) u_run_rise (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .src(chg_stat.detect_running),
    .clr(chg_clr[TCIRQ_RUN_RISE_BIT]),
    .flag(chg_flags[TCIRQ_RUN_RISE_BIT])
  );

  tcirq_evt_flag #(.W(1), .KIND(TCIRQ_ON_FALL)) u_run_fall (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .src(chg_stat.detect_running),
    .clr(chg_clr[TCIRQ_RUN_FALL_BIT]),
    .flag(chg_flags[TCIRQ_RUN_FALL_BIT])
  );

  // Data-contact timeout status entered or left
  tcirq_evt_flag #(.W(1), .KIND(TCIRQ_ON_CHANGE)) u_contact_tmo (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .src(chg_stat.contact_timeout),
    .clr(chg_clr[TCIRQ_CONTACT_TMO_BIT]),
    .flag(chg_flags[TCIRQ_CONTACT_TMO_BIT])
  );

  // Supply path event flags
  assign sup_flags[7:2] = 6'h00;

  // Supply switch opened or closed
  tcirq_evt_flag #(.W(1), .KIND(TCIRQ_ON_CHANGE)) u_supply_switch (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .src(sup_stat.switch_closed),
    .clr(sup_clr[TCIRQ_SUPPLY_SWITCH_BIT]),
    .flag(sup_flags[TCIRQ_SUPPLY_SWITCH_BIT])
  );

  // Supply overvoltage entered or left
  tcirq_evt_flag #(.W(1), .KIND(TCIRQ_ON_CHANGE)) u_supply_ovp (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .src(sup_stat.overvolt),
    .clr(sup_clr[TCIRQ_SUPPLY_OVERVOLT_BIT]),
    .flag(sup_flags[TCIRQ_SUPPLY_OVERVOLT_BIT])
  );

  // Accessory resistor flags, one cell per accessory strobe
  assign acc_flags[7:TCIRQ_ACC_COUNT] = '0;

  for (genvar i = 0; i < TCIRQ_ACC_COUNT; i++) begin : g_acc
    tcirq_evt_flag #(.W(1), .KIND(TCIRQ_ON_PULSE)) u_acc (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .src(res_evt.accessory[i]),
      .clr(acc_clr[i]),
      .flag(acc_flags[i])
    );
  end

  // Resistance result flags
  assign res_flags[7:6] = 2'h0;

  // Measurement found a grounded line
  tcirq_evt_flag #(.W(1), .KIND(TCIRQ_ON_PULSE)) u_res_ground (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .src(res_evt.grounded),
    .clr(res_clr[TCIRQ_RES_GROUND_BIT]),
    .flag(res_flags[TCIRQ_RES_GROUND_BIT])
  );

  // Sideband resistor measurement completed
  tcirq_evt_flag #(.W(1), .KIND(TCIRQ_ON_PULSE)) u_res_done (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .src(res_evt.meas_done),
    .clr(res_clr[TCIRQ_RES_DONE_BIT]),
    .flag(res_flags[TCIRQ_RES_DONE_BIT])
  );

  tcirq_evt_flag #(.W(1), .KIND(TCIRQ_ON_PULSE)) u_res_finite (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .src(res_evt.invalid_finite),
    .clr(res_clr[TCIRQ_RES_FINITE_BIT]),
    .flag(res_flags[TCIRQ_RES_FINITE_BIT])
  );

  tcirq_evt_flag #(.W(1), .KIND(TCIRQ_ON_PULSE)) u_res_open (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .src(res_evt.open),
    .clr(res_clr[TCIRQ_RES_OPEN_BIT]),
    .flag(res_flags[TCIRQ_RES_OPEN_BIT])
  );

  tcirq_evt_flag #(.W(1), .KIND(TCIRQ_ON_PULSE)) u_res_abort (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .src(res_evt.aborted),
    .clr(res_clr[TCIRQ_RES_ABORT_BIT]),
    .flag(res_flags[TCIRQ_RES_ABORT_BIT])
  );

  // Valid moisture detection result obtained
  tcirq_evt_flag #(.W(1), .KIND(TCIRQ_ON_PULSE)) u_res_moist (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .src(res_evt.moisture_valid),
    .clr(res_clr[TCIRQ_RES_MOIST_BIT]),
    .flag(res_flags[TCIRQ_RES_MOIST_BIT])
  );

  // Read mux; unmapped addresses answer zero
  always_comb begin
    unique case (reg_req.addr)
      TCIRQ_OFS_CONN: rdata_nxt = conn_flags;
      TCIRQ_OFS_CHG: rdata_nxt = chg_flags;
      TCIRQ_OFS_SUP: rdata_nxt = sup_flags;
      TCIRQ_OFS_ACC: rdata_nxt = acc_flags;
      TCIRQ_OFS_RES: rdata_nxt = res_flags;
      default: rdata_nxt = TCIRQ_FLAGS_RST;
    endcase
  end

  // Read data is captured on a read and held until the next one
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= TCIRQ_FLAGS_RST;
    end else if (reg_req.rd) begin
      rdata_r <= rdata_nxt;
    end
  end

  // Read answer strobe, one cycle after the request
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= reg_req.rd;
    end
  end

  // Summary of all flags, telling the host a status read is due
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pending_r <= 1'b0;
    end else begin
      pending_r <= |{conn_flags, chg_flags, sup_flags, acc_flags, res_flags};
    end
  end

  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;
  assign flag_pending = pending_r;

endmodule

// *** verif/tcirq_flags_sva.sv ***
`timescale 1ns/1ns
module tcirq_flags_chk
  import tcirq_pkg::*;
(
  input wire logic core_clk, // Clock
  input wire logic rst_b, // Reset, active low
  input tcirq_pkg::tcirq_conn_stat_t conn_stat, // Connector status
  input tcirq_pkg::tcirq_chg_stat_t chg_stat, // Charge status
  input tcirq_pkg::tcirq_sup_stat_t sup_stat, // Supply status
  input tcirq_pkg::tcirq_res_evt_t res_evt, // Result strobes
  input tcirq_pkg::tcirq_reg_req_t reg_req, // Register request
  input wire logic [tcirq_pkg::TCIRQ_DATA_W-1:0] reg_rdata, // Read data
  input wire logic reg_rvalid, // Read valid
  input wire logic flag_pending // Any flag set
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Event past the baseline edge, then a read of its register
  sequence s_ev_read(ev, a);
    ev && $past(rst_b) ##2 (reg_req.rd && reg_req.addr == a);
  endsequence
  // The read returns the flag set
  property p_bit(ev, a, b);
    s_ev_read(ev, a) |=> reg_rdata[b];
  endproperty
  a_read_valid: assert property (reg_req.rd |=> reg_rvalid) else $error("read without valid");
  a_valid_cause: assert property (!reg_req.rd |=> !reg_rvalid) else $error("stray valid");
  a_rdata_hold: assert property (!reg_req.rd |=> $stable(reg_rdata)) else $error("data moved");
  a_unmapped_zero: assert property (reg_req.rd && !(reg_req.addr inside {[8'h02:8'h06]})
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_reserved_zero: assert property (reg_req.rd && reg_req.addr == TCIRQ_OFS_SUP
    |=> reg_rdata[7:2] == 6'h00) else $error("reserved bits set");
  a_reset_clear: assert property (disable iff (1'b0) !rst_b
    |-> reg_rdata == 8'h00 && !reg_rvalid && !flag_pending) else $error("reset not clear");
  a_conn_state: assert property (p_bit($changed(conn_stat.conn_state), TCIRQ_OFS_CONN, 5))
    else $error("state flag missing");
  a_abort_flag: assert property (p_bit(conn_stat.detect_abort, TCIRQ_OFS_CONN, 0))
    else $error("abort flag missing");
  a_run_rise: assert property (p_bit($rose(chg_stat.detect_running), TCIRQ_OFS_CHG, 2))
    else $error("rise flag missing");
  a_run_fall: assert property (p_bit($fell(chg_stat.detect_running), TCIRQ_OFS_CHG, 1))
    else $error("fall flag missing");
  a_switch_flag: assert property (p_bit($changed(sup_stat.switch_closed), TCIRQ_OFS_SUP, 1))
    else $error("switch flag missing");
  a_pending_set: assert property ((|res_evt) && $past(rst_b) |-> ##[2:3] flag_pending)
    else $error("pending not raised");
endmodule
bind tcirq_flags tcirq_flags_chk u_chk (.core_clk, .rst_b, .conn_stat, .chg_stat, .sup_stat,
  .res_evt, .reg_req, .reg_rdata, .reg_rvalid, .flag_pending);

// *** verif/tcirq_host_model.sv ***
`timescale 1ns/1ns
module tcirq_host_model
  import tcirq_pkg::*;
(
  input wire logic core_clk, // Clock
  output tcirq_pkg::tcirq_reg_req_t reg_req, // Request to the flags
  input wire logic [tcirq_pkg::TCIRQ_DATA_W-1:0] reg_rdata, // Read data
  input wire logic reg_rvalid // Read valid
);
  // Idle until the first access
  initial reg_req = '0;
  // One access; a flag only says something changed, so callers reread status
  task automatic xfer(input logic w, input logic r, input logic [7:0] a, input logic [7:0] wd,
                      output logic v, output logic [7:0] d);
    @(posedge core_clk);
    reg_req <= '{wr: w, rd: r, addr: a, wdata: wd};
    @(posedge core_clk);
    reg_req <= '0;
    #1;
    v = reg_rvalid;
    d = reg_rdata;
  endtask
endmodule

// *** verif/test_tcirq_flags.sv ***
`timescale 1ns/1ns
module test_tcirq_flags;
  import tcirq_pkg::*;
  logic core_clk = 1'b0; // Clock
  logic rst_b = 1'b1; // Reset, active low; pulled low at time zero
  tcirq_conn_stat_t conn = '0; // Connector status
  tcirq_chg_stat_t chg = '0; // Charge status
  tcirq_sup_stat_t sup = '0; // Supply status
  tcirq_res_evt_t res = '0; // Result strobes
  tcirq_reg_req_t req; // Host request
  logic [7:0] rdata; // Read data
  logic rvalid, pend; // Read valid, any flag
  int n_fail = 0; // Mismatches
  int check_count = 0; // Comparisons
  // Clock, 20 ns period
  always #10 core_clk = ~core_clk;
  tcirq_flags dut (.core_clk, .rst_b, .conn_stat(conn), .chg_stat(chg), .sup_stat(sup),
    .res_evt(res), .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid), .flag_pending(pend));
  tcirq_host_model host (.core_clk, .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid));
  // Byte compare
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Bit compare
  task automatic chk1(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask
  // Read a register and compare it
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic v;
    logic [7:0] d;
    host.xfer(1'b0, 1'b1, a, 8'h00, v, d);
    chk1("read valid", 1'b1, v);
    chk8("read data", e, d);
  endtask
  // Write a register
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic v;
    logic [7:0] q;
    host.xfer(1'b1, 1'b0, a, d, v, q);
  endtask
  // Register and bit where event i lands
  function automatic logic [10:0] loc(input int i, input logic run);
    case (i) inside
      [0:5]: return {TCIRQ_OFS_CONN, 3'(5 - i)};
      [6:7]: return {TCIRQ_OFS_CHG, 3'(10 - i)};
      8: return {TCIRQ_OFS_CHG, run ? 3'h2 : 3'h1};
      9: return {TCIRQ_OFS_CHG, 3'h0};
      [10:11]: return {TCIRQ_OFS_SUP, 3'(11 - i)};
      [12:16]: return {TCIRQ_OFS_ACC, 3'(i - 12)};
      default: return {TCIRQ_OFS_RES, 3'(22 - i)};
    endcase
  endfunction
  // Make event i: a field change, random for multi-bit fields and a toggle for single bits, or a one-cycle strobe
  task automatic fire(input int i);
    tcirq_conn_stat_t c;
    tcirq_chg_stat_t g;
    tcirq_sup_stat_t s;
    tcirq_res_evt_t r;
    c = conn;
    g = chg;
    s = sup;
    r = '0;
    case (i) inside
      0: c.conn_state ^= 3'h1 + 3'($urandom_range(6));
      1: c.pin_orient ^= 2'h1 + 2'($urandom_range(2));
      2: c.adv_current ^= 2'h1 + 2'($urandom_range(2));
      3: c.cable_power_state ^= 1'b1;
      4: c.cable_power_overcurrent ^= 1'b1;
      5: c.detect_abort = 1'b1;
      6: g.charger_kind ^= 2'h1 + 2'($urandom_range(2));
      7: g.vendor_charger_kind ^= 4'h1 + 4'($urandom_range(14));
      8: g.detect_running ^= 1'b1;
      9: g.contact_timeout ^= 1'b1;
      10: s.switch_closed ^= 1'b1;
      11: s.overvolt ^= 1'b1;
      [12:16]: r.accessory[i - 12] = 1'b1;
      default: r = 11'h001 << (22 - i);
    endcase
    @(posedge core_clk);
    conn <= c;
    chg <= g;
    sup <= s;
    res <= r;
    @(posedge core_clk);
    conn.detect_abort <= 1'b0;
    res <= '0;
  endtask
  // Event sets one bit only, write zero keeps it, write one clears it
  task automatic one_event(input int i);
    logic [10:0] l;
    logic [7:0] m;
    fire(i);
    l = loc(i, chg.detect_running);
    m = 8'h01 << l[2:0];
    rd(l[10:3], m);
    chk1("pending", 1'b1, pend);
    wr(l[10:3], ~m);
    rd(l[10:3], m);
    wr(l[10:3], m);
    rd(l[10:3], 8'h00);
    chk1("pending clear", 1'b0, pend);
    $display("test event %0d done", i);
  endtask
  // Verdict and end of run
  task automatic complete_run;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    logic v;
    logic [7:0] d;
    rst_b <= 1'b0; // A real falling edge clears every flop before the first clock
    void'($urandom(32'hC690));
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    for (int a = 2; a <= 6; a++) rd(8'(a), TCIRQ_FLAGS_RST);
    wr(8'h07, 8'hFF);
    rd(8'h07, 8'h00);
    rd(8'h00, 8'h00);
    $display("test reset and unmapped done");
    for (int i = 0; i < 23; i++) one_event(i);
    one_event(8);
    repeat (23) one_event($urandom_range(22));
    fire(17);
    host.xfer(1'b1, 1'b1, TCIRQ_OFS_RES, 8'h20, v, d);
    chk8("read with clear", 8'h20, d);
    rd(TCIRQ_OFS_RES, 8'h00);
    $display("test read with clear done");
    fire(5);
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(TCIRQ_OFS_CONN, 8'h00);
    $display("test mid-run reset done");
    complete_run();
  end
  // Watchdog, far beyond the few hundred cycles of the run
  initial begin
    #200000;
    n_fail++;
    complete_run();
  end
endmodule
